/* File: design/sgp_sector_guard.sv */
`timescale 1ns/100ps
module sgp_sector_guard
  import sgp_pkg::*;
#(
  parameter int unsigned SECTORS = GUARD_SECTORS,
  parameter int unsigned PUW_CYCLES = PUW_CYC,
  parameter int unsigned SE_CYCLES = SE_CYC,
  parameter int unsigned BE_CYCLES = BE_CYC,
  parameter int unsigned CE_CYCLES = CE_CYC,
  parameter int unsigned PP_CYCLES = PP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic vcc_ok_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  output logic ready_o,
  output logic busy_o,
  output logic write_latch_flag_o,
  output logic op_start_o,
  output logic [1:0] op_kind_o,
  output logic [23:0] op_addr_o
);
  localparam int unsigned AW = $clog2(SECTORS / 8);

  if (SECTORS % 8 != 0 || SECTORS < 16 || SECTORS > 4096) begin : g_chk_s
    $error("Sector count must be a multiple of 8 within 16 to 4096");
  end
  if (PUW_CYCLES < 1 || SE_CYCLES < 1 || BE_CYCLES < 1 || CE_CYCLES < 1 ||
      PP_CYCLES < 1) begin : g_chk_t
    $error("Cycle counts must be at least one");
  end

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] sck_s;
    logic [2:0] si_s;
    logic [2:0] vcc_s;
    logic cs_f;
    logic sck_f;
    logic vcc_f;
    logic [31:0] por_cnt;
    logic ready;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] shreg;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] so_sh;
    logic so;
    logic so_oe;
    logic write_latch_flag;
    logic busy;
    logic [31:0] busy_cnt;
    logic [2:0] key_step;
    logic gprog;
    logic fill;
    logic [AW-1:0] fill_idx;
    logic mem_we;
    logic [AW-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    sgp_chk_t chk;
    sgp_op_t kind;
    logic op_start;
    sgp_op_t op_kind;
    logic [23:0] op_addr;
  } sgp_state_t;

  localparam sgp_state_t ST_RST = '{
    chk: CK_IDLE, kind: OPK_PROG, op_kind: OPK_PROG, cs_s: 3'h7,
    cs_f: 1'b1, default: '0};

  sgp_state_t st_ff;
  sgp_state_t nxt_st;
  logic [7:0] rdata;
  logic [AW-1:0] raddr;

  // Map byte that holds the guard bit of an array address
  function automatic logic [AW-1:0] guard_idx(input logic [23:0] a);
    guard_idx = a[SECTOR_SHIFT+3 +: AW];
  endfunction

  // Busy length of a main array operation
  function automatic logic [31:0] op_cycles(input sgp_op_t k);
    unique case (k)
      OPK_PROG: op_cycles = 32'(PP_CYCLES);
      OPK_SERASE: op_cycles = 32'(SE_CYCLES);
      OPK_BERASE: op_cycles = 32'(BE_CYCLES);
      OPK_CERASE: op_cycles = 32'(CE_CYCLES);
    endcase
  endfunction

  // Expected opcode at each step of the unlock run
  function automatic logic [7:0] key_code(input logic [2:0] step);
    unique case (step)
      3'h0: key_code = OP_WREN;
      3'h1: key_code = OP_KEY1;
      3'h2: key_code = OP_KEY2;
      3'h3: key_code = OP_KEY3;
      default: key_code = 8'h00;
    endcase
  endfunction

  // Map byte addressed by the current frame, in range or not
  function automatic logic map_hit(input logic [23:0] a);
    map_hit = a >= GUARD_BASE && a <= GUARD_BASE + 24'(SECTORS / 8 - 1);
  endfunction

  assign raddr = (st_ff.chk == CK_WAIT) ? guard_idx(st_ff.addr) :
                 st_ff.addr[AW-1:0];

  sgp_guard_mem #(.AW(AW), .DW(8)) u_mem (
    .ref_clk_i(ref_clk_i),
    .we_i(st_ff.mem_we),
    .waddr_i(st_ff.mem_waddr),
    .wdata_i(st_ff.mem_wdata),
    .raddr_i(raddr),
    .rdata_o(rdata)
  );

  // Next state
  always_comb begin
    logic [7:0] in_byte;
    logic [7:0] out_byte;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic reading;
    in_byte = '0;
    out_byte = '0;
    nxt_st = st_ff;
    // Pin synchronisers; a cs, sck or vcc level counts once stages two and three agree
    nxt_st.cs_s = {st_ff.cs_s[1:0], cs_n_i};
    nxt_st.sck_s = {st_ff.sck_s[1:0], sck_i};
    nxt_st.si_s = {st_ff.si_s[1:0], si_i};
    nxt_st.vcc_s = {st_ff.vcc_s[1:0], vcc_ok_i};
    if (st_ff.cs_s[1] == st_ff.cs_s[2]) nxt_st.cs_f = st_ff.cs_s[2];
    if (st_ff.sck_s[1] == st_ff.sck_s[2]) nxt_st.sck_f = st_ff.sck_s[2];
    if (st_ff.vcc_s[1] == st_ff.vcc_s[2]) nxt_st.vcc_f = st_ff.vcc_s[2];
    sck_rise = nxt_st.sck_f && !st_ff.sck_f && !st_ff.cs_f;
    sck_fall = !nxt_st.sck_f && st_ff.sck_f && !st_ff.cs_f;
    cs_fall = !nxt_st.cs_f && st_ff.cs_f;
    cs_rise = nxt_st.cs_f && !st_ff.cs_f;
    reading = (st_ff.byte_cnt >= 3'h1 && st_ff.opcode == OP_RDSR) ||
              (st_ff.byte_cnt >= 3'h4 && st_ff.opcode == OP_GRD_RD &&
               !st_ff.busy);
    nxt_st.mem_we = 1'b0;
    nxt_st.op_start = 1'b0;
    // Power-up write delay before any instruction is served
    if (!st_ff.ready) begin
      if (st_ff.por_cnt == 32'(PUW_CYCLES - 1)) nxt_st.ready = 1'b1;
      else nxt_st.por_cnt = st_ff.por_cnt + 32'h1;
    end
    // Busy timer of program and erase
    if (st_ff.busy) begin
      if (st_ff.busy_cnt == 32'h0) nxt_st.busy = 1'b0;
      else nxt_st.busy_cnt = st_ff.busy_cnt - 32'h1;
    end
    // Map erase sweep sets every bit to unguarded
    if (st_ff.fill) begin
      nxt_st.mem_we = 1'b1;
      nxt_st.mem_waddr = st_ff.fill_idx;
      nxt_st.mem_wdata = BYTE_ERASED;
      nxt_st.fill_idx = st_ff.fill_idx + 1'b1;
      if (&st_ff.fill_idx) nxt_st.fill = 1'b0;
    end
    if (cs_fall) begin
      nxt_st.bit_cnt = 3'h0;
      nxt_st.byte_cnt = 3'h0;
      nxt_st.gprog = 1'b0;
    end
    // Serial input on rising clock
    if (sck_rise && st_ff.ready) begin
      in_byte = {st_ff.shreg[6:0], st_ff.si_s[2]};
      nxt_st.shreg = in_byte;
      nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
      if (st_ff.bit_cnt == 3'h7) begin
        if (st_ff.byte_cnt != 3'h4) nxt_st.byte_cnt = st_ff.byte_cnt + 3'h1;
        if (st_ff.byte_cnt == 3'h0) begin
          nxt_st.opcode = in_byte;
          nxt_st.gprog = in_byte == OP_GRD_PG && st_ff.key_step == KEY_DONE &&
                         st_ff.write_latch_flag && !st_ff.busy;
        end else if (st_ff.byte_cnt < 3'h4) begin
          nxt_st.addr = {st_ff.addr[15:0], in_byte};
        end else begin
          if (st_ff.opcode == OP_GRD_RD) nxt_st.addr = st_ff.addr + 24'h1;
          if (st_ff.gprog) begin
            // Program only clears bits, as flash cells do
            nxt_st.mem_we = map_hit(st_ff.addr);
            nxt_st.mem_waddr = st_ff.addr[AW-1:0];
            nxt_st.mem_wdata = rdata & in_byte;
            nxt_st.addr = st_ff.addr + 24'h1;
          end
        end
      end
    end
    // Serial output on falling clock, MSB first
    if (sck_fall && st_ff.ready && reading) begin
      nxt_st.so_oe = 1'b1;
      if (st_ff.bit_cnt == 3'h0) begin
        if (st_ff.opcode == OP_RDSR) begin
          out_byte[ST_BUSY_BIT] = st_ff.busy;
          out_byte[ST_WEL_BIT] = st_ff.write_latch_flag;
        end else begin
          out_byte = map_hit(st_ff.addr) ? rdata : BYTE_ERASED;
        end
        nxt_st.so = out_byte[7];
        nxt_st.so_sh = {out_byte[6:0], 1'b0};
      end else begin
        nxt_st.so = st_ff.so_sh[7];
        nxt_st.so_sh = {st_ff.so_sh[6:0], 1'b0};
      end
    end
    // Frame end: whole bytes only, then act on the instruction
    if (cs_rise) begin
      nxt_st.so_oe = 1'b0;
      nxt_st.so = 1'b0;
    end
    if (cs_rise && st_ff.ready && st_ff.bit_cnt == 3'h0) begin
      if (st_ff.byte_cnt == 3'h1 && st_ff.key_step < KEY_DONE &&
          st_ff.opcode == key_code(st_ff.key_step)) begin
        nxt_st.key_step = st_ff.key_step + 3'h1;
      end else begin
        nxt_st.key_step = 3'h0;
      end
      if (!st_ff.busy && st_ff.chk == CK_IDLE && !st_ff.fill) begin
        unique case (st_ff.opcode)
          OP_WREN: if (st_ff.byte_cnt == 3'h1) nxt_st.write_latch_flag = 1'b1;
          OP_WRDI: nxt_st.write_latch_flag = 1'b0;
          OP_PP, OP_SE, OP_BE: begin
            if (st_ff.write_latch_flag && st_ff.byte_cnt == 3'h4) begin
              nxt_st.chk = CK_WAIT;
              nxt_st.write_latch_flag = 1'b0;
              nxt_st.kind = st_ff.opcode == OP_PP ? OPK_PROG :
                            st_ff.opcode == OP_SE ? OPK_SERASE : OPK_BERASE;
            end
          end
          OP_CE: begin
            if (st_ff.write_latch_flag && st_ff.byte_cnt == 3'h1) begin
              nxt_st.write_latch_flag = 1'b0;
              nxt_st.op_start = 1'b1;
              nxt_st.op_kind = OPK_CERASE;
              nxt_st.op_addr = '0;
              nxt_st.busy = 1'b1;
              nxt_st.busy_cnt = op_cycles(OPK_CERASE) - 32'h1;
            end
          end
          OP_GRD_ER: begin
            if (st_ff.write_latch_flag && st_ff.byte_cnt == 3'h1 &&
                st_ff.key_step == KEY_DONE) begin
              nxt_st.write_latch_flag = 1'b0;
              nxt_st.fill = 1'b1;
              nxt_st.fill_idx = '0;
              nxt_st.busy = 1'b1;
              nxt_st.busy_cnt = 32'(SE_CYCLES - 1);
            end
          end
          OP_GRD_PG: begin
            if (st_ff.gprog) begin
              nxt_st.write_latch_flag = 1'b0;
              nxt_st.busy = 1'b1;
              nxt_st.busy_cnt = 32'(PP_CYCLES - 1);
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Guard lookup of the addressed sector
    unique case (st_ff.chk)
      CK_IDLE: begin
      end
      CK_WAIT: nxt_st.chk = CK_EVAL;
      CK_EVAL: begin
        nxt_st.chk = CK_IDLE;
        if (rdata[st_ff.addr[SECTOR_SHIFT +: 3]]) begin
          nxt_st.op_start = 1'b1;
          nxt_st.op_kind = st_ff.kind;
          nxt_st.op_addr = st_ff.addr;
          nxt_st.busy = 1'b1;
          nxt_st.busy_cnt = op_cycles(st_ff.kind) - 32'h1;
        end
      end
    endcase
    // Supply below threshold: everything but the synchronisers in reset
    if (!st_ff.vcc_f) begin
      nxt_st = ST_RST;
      nxt_st.cs_s = {st_ff.cs_s[1:0], cs_n_i};
      nxt_st.sck_s = {st_ff.sck_s[1:0], sck_i};
      nxt_st.si_s = {st_ff.si_s[1:0], si_i};
      nxt_st.vcc_s = {st_ff.vcc_s[1:0], vcc_ok_i};
      if (st_ff.vcc_s[1] == st_ff.vcc_s[2]) nxt_st.vcc_f = st_ff.vcc_s[2];
      if (st_ff.cs_s[1] == st_ff.cs_s[2]) nxt_st.cs_f = st_ff.cs_s[2];
      if (st_ff.sck_s[1] == st_ff.sck_s[2]) nxt_st.sck_f = st_ff.sck_s[2];
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign so_o = st_ff.so;
  assign so_oe_o = st_ff.so_oe;
  assign ready_o = st_ff.ready;
  assign busy_o = st_ff.busy;
  assign write_latch_flag_o = st_ff.write_latch_flag;
  assign op_start_o = st_ff.op_start;
  assign op_kind_o = st_ff.op_kind;
  assign op_addr_o = st_ff.op_addr;
endmodule

/* File: design/sgp_pkg.sv */
// Behaviour
// - One guard bit per 4 KB sector; 0 means guarded, 1 unguarded.
// - Sector n sits in map byte n/8 at bit n mod 8, from byte 000h.
// - Logic held in reset below threshold; instructions ignored until delay.
// - After power-up the device idles with the write latch cleared.
// - Supply below write-inhibit threshold disables every write operation.
// - Erase ends within 150 ms sector, 0.5 s block, 6 s chip.
// - Page program ends within 0.7 ms of the command.
// - Map read: three address bytes, data MSB first, address steps per byte.
// - Map erase or program needs a correct five-instruction run.
package sgp_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_KHZ = 20_000;
  // Sector and map layout
  localparam int unsigned SECTOR_SHIFT = 12;
  localparam int unsigned GUARD_SECTORS = 256;
  localparam logic [23:0] GUARD_BASE = 24'h000000;
  localparam logic [23:0] GUARD_LAST = 24'h00001F;
  // Timing figures as printed
  localparam int unsigned T_PUW_MIN_MS = 1;
  localparam int unsigned T_PUW_MAX_MS = 10;
  localparam int unsigned T_VCE_MIN_US = 10;
  localparam real V_WI_MIN_V = 1.3;
  localparam int unsigned T_SE_MAX_MS = 150;
  localparam real T_BE_MAX_S = 0.5;
  localparam int unsigned T_CE_MAX_S = 6;
  localparam real T_PP_MAX_MS = 0.7;
  // Cycle counts; least times round up, longest round down
  localparam int unsigned PUW_CYC = (T_PUW_MIN_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned SE_CYC = T_SE_MAX_MS * CLK_KHZ;
  localparam int unsigned BE_CYC = int'($floor(T_BE_MAX_S * CLK_HZ));
  localparam int unsigned CE_CYC = T_CE_MAX_S * CLK_HZ;
  // Small offset absorbs binary error of 0.7
  localparam int unsigned PP_CYC = int'($floor(T_PP_MAX_MS * CLK_KHZ + 1.0e-6));
  // Instruction codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE = 8'hD8;
  localparam logic [7:0] OP_CE = 8'hC7;
  localparam logic [7:0] OP_GRD_RD = 8'h48;
  localparam logic [7:0] OP_GRD_ER = 8'h44;
  localparam logic [7:0] OP_GRD_PG = 8'h42;
  localparam logic [7:0] OP_KEY1 = 8'h3A;
  localparam logic [7:0] OP_KEY2 = 8'h5C;
  localparam logic [7:0] OP_KEY3 = 8'h6E;
  localparam logic [2:0] KEY_DONE = 3'h4;
  // Status byte fields
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_WEL_BIT = 1;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  // Main array operation kinds
  typedef enum logic [1:0] {OPK_PROG, OPK_SERASE, OPK_BERASE, OPK_CERASE}
    sgp_op_t;
  // Guard lookup phases
  typedef enum logic [1:0] {CK_IDLE, CK_WAIT, CK_EVAL} sgp_chk_t;
endpackage

/* File: design/sgp_guard_mem.sv */
`timescale 1ns/100ps
module sgp_guard_mem #(
  parameter int unsigned AW = 5,
  parameter int unsigned DW = 8
) (
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_ff [2**AW];
  logic [DW-1:0] rdata_ff;

  // Write port and registered read port; contents survive reset
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    rdata_ff <= mem_ff[raddr_i];
  end

  assign rdata_o = rdata_ff;
endmodule

/* File: bench/sgp_chk.sv */
`timescale 1ns/100ps
module sgp_chk
  import sgp_pkg::*;
#(
  parameter int unsigned PUW_CYCLES = PUW_CYC,
  parameter int unsigned SE_CYCLES = SE_CYC,
  parameter int unsigned BE_CYCLES = BE_CYC,
  parameter int unsigned CE_CYCLES = CE_CYC,
  parameter int unsigned PP_CYCLES = PP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic vcc_ok_i,
  input wire logic cs_n_i,
  input wire logic so_oe_o,
  input wire logic ready_o,
  input wire logic busy_o,
  input wire logic write_latch_flag_o,
  input wire logic op_start_o,
  input wire logic [1:0] op_kind_o,
  input wire logic [23:0] op_addr_o
);
  typedef struct packed {
    logic [31:0] up;
    logic [31:0] bsy;
    logic [31:0] lim;
  } sgp_mon_t;
  sgp_mon_t st_ff;
  sgp_mon_t nxt_st;
  // Power-up wait, busy length and busy limit of the running operation
  always_comb begin
    nxt_st = st_ff;
    nxt_st.up = (!vcc_ok_i || ready_o) ? 32'h0 : st_ff.up + 32'h1;
    nxt_st.bsy = busy_o ? st_ff.bsy + 32'h1 : 32'h0;
    if (op_start_o) begin
      nxt_st.lim = (op_kind_o == OPK_PROG) ? PP_CYCLES :
        (op_kind_o == OPK_SERASE) ? SE_CYCLES :
        (op_kind_o == OPK_BERASE) ? BE_CYCLES : CE_CYCLES;
    end else if (!busy_o) begin
      nxt_st.lim = SE_CYCLES + 32; // Map work includes the sweep
    end
    if (!resetn_i) begin
      nxt_st = '0;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    st_ff <= nxt_st;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_i |=>
    !ready_o && !busy_o && !write_latch_flag_o && !so_oe_o)
    else $error("outputs active after reset");
  a_ready_early: assert property ($rose(ready_o) |->
    st_ff.up >= PUW_CYCLES) else $error("ready before power-up delay");
  a_op_ready: assert property (op_start_o |-> ready_o && !$past(busy_o))
    else $error("operation started while not ready or busy");
  a_start_busy: assert property (op_start_o |-> ##[0:1] busy_o)
    else $error("operation without busy");
  a_busy_bound: assert property (busy_o |-> st_ff.bsy <= st_ff.lim)
    else $error("busy longer than its limit");
  a_low_vcc: assert property (!vcc_ok_i [*6] |->
    !write_latch_flag_o && !busy_o && !ready_o)
    else $error("write state alive on low supply");
  a_oe_cs: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("output driven while deselected");
  a_op_hold: assert property (!op_start_o && ready_o |->
    $stable(op_addr_o) && $stable(op_kind_o))
    else $error("operation fields changed without a start");
  c_chip: cover property (op_start_o && op_kind_o == 2'h3);
  c_read: cover property ($fell(so_oe_o));
  c_ready: cover property ($rose(ready_o));
endmodule
bind sgp_sector_guard sgp_chk #(.PUW_CYCLES(PUW_CYCLES),
  .SE_CYCLES(SE_CYCLES), .BE_CYCLES(BE_CYCLES), .CE_CYCLES(CE_CYCLES),
  .PP_CYCLES(PP_CYCLES)) u_chk (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .vcc_ok_i(vcc_ok_i), .cs_n_i(cs_n_i),
  .so_oe_o(so_oe_o), .ready_o(ready_o), .busy_o(busy_o),
  .write_latch_flag_o(write_latch_flag_o), .op_start_o(op_start_o),
  .op_kind_o(op_kind_o), .op_addr_o(op_addr_o));

/* File: bench/sgp_host.sv */
`timescale 1ns/100ps
module sgp_host (
  input wire logic ref_clk_i,
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  logic [7:0] tx [40];
  logic [7:0] rx_byte;
  logic rx_stb;
  int half = 8;
  // Deselected and clock parked low until a frame is asked for
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end
  // One mode 0 frame: n bytes sent, then nrd bytes read back
  task automatic frame(input int n, input int nrd);
    logic [7:0] b;
    cs_n_o <= 1'b0;
    repeat (half) @(posedge ref_clk_i);
    for (int i = 0; i < n + nrd; i++) begin
      for (int k = 7; k >= 0; k--) begin
        si_o <= tx[i][k];
        repeat (half) @(posedge ref_clk_i);
        sck_o <= 1'b1;
        b = {b[6:0], so_i};
        repeat (half) @(posedge ref_clk_i);
        sck_o <= 1'b0;
      end
      if (i >= n) begin
        rx_byte <= b;
        rx_stb <= 1'b1;
        @(posedge ref_clk_i);
        rx_stb <= 1'b0;
      end
    end
    repeat (half) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o; // Released line must not hold its last value
    repeat (half) @(posedge ref_clk_i);
  endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import sgp_pkg::*;
  localparam int unsigned PUW = 20;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic vcc_ok_i = 1'b0;
  logic cs_n, sck, si, so, so_oe, ready, busy, write_latch_flag, op_start;
  logic [1:0] op_kind;
  logic [23:0] op_addr;
  logic [7:0] lfsr = 8'h38;
  logic [7:0] exp_rx [$];
  logic [25:0] exp_op [$];
  int n_fail = 0;
  int comparisons = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  sgp_sector_guard #(.PUW_CYCLES(PUW), .SE_CYCLES(50), .BE_CYCLES(60),
    .CE_CYCLES(70), .PP_CYCLES(40)) DUT (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .vcc_ok_i(vcc_ok_i), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .so_o(so), .so_oe_o(so_oe), .ready_o(ready), .busy_o(busy),
    .write_latch_flag_o(write_latch_flag), .op_start_o(op_start), .op_kind_o(op_kind),
    .op_addr_o(op_addr));
  sgp_host u_host (.ref_clk_i(ref_clk_i), .so_i(so), .cs_n_o(cs_n),
    .sck_o(sck), .si_o(si));
  function automatic logic [7:0] rnd(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Frame of up to five given bytes, random filler after them
  task automatic send(input logic [39:0] v, input int n, input int nrd);
    for (int i = 0; i < 40; i++) begin
      lfsr = rnd(lfsr);
      u_host.tx[i] = (i < n) ? v[39 - 8 * i -: 8] : lfsr;
    end
    u_host.frame(n, nrd);
  endtask
  task automatic unlock();
    send({OP_WREN, 32'h0}, 1, 0);
    send({OP_KEY1, 32'h0}, 1, 0);
    send({OP_KEY2, 32'h0}, 1, 0);
    send({OP_KEY3, 32'h0}, 1, 0);
  endtask
  task automatic idle();
    int k;
    k = 0;
    repeat (4) @(posedge ref_clk_i);
    while (busy !== 1'b0 && k < 400) begin
      @(posedge ref_clk_i);
      k++;
    end
    if (k == 400) begin
      chk("busy wait", 0, 1);
      stop_test();
    end
  endtask
  task automatic wait_ready();
    int t;
    t = 0;
    while (ready !== 1'b1 && t < 2000) begin
      @(posedge ref_clk_i);
      t++;
    end
    chk("power-up delay", 1, ready === 1'b1 && t >= PUW);
    if (t == 2000) begin
      stop_test();
    end
    chk("latch after power-up", 0, write_latch_flag);
    chk("busy after power-up", 0, busy);
  endtask
  // Retire expected read bytes and array starts in order
  always @(posedge ref_clk_i) begin
    if (u_host.rx_stb === 1'b1) begin
      chk("map byte", exp_rx.size() ? 32'(exp_rx.pop_front()) : 'x, 32'(u_host.rx_byte));
    end
    if (op_start === 1'b1) begin
      chk("array op", exp_op.size() ? 32'(exp_op.pop_front()) : 'x, {6'h0, op_kind, op_addr});
    end
  end
  // Main sequence
  initial begin
    logic [31:0] opv [6];
    sgp_op_t kinds [6];
    logic [5:0] open_ok;
    logic [31:0] a;
    opv = '{{OP_SE, 24'h000000}, {OP_SE, 24'h001000}, {OP_BE, 24'h010000},
      {OP_PP, 24'h0FF000}, {OP_PP, 24'h002000}, {OP_CE, 24'h000000}};
    kinds = '{OPK_SERASE, OPK_SERASE, OPK_BERASE, OPK_PROG, OPK_PROG,
      OPK_CERASE};
    open_ok = 6'b110110;
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    // Write enable sent on a low supply must not take
    send({OP_WREN, 32'h0}, 1, 0);
    chk("latch on low supply", 0, write_latch_flag);
    vcc_ok_i <= 1'b1;
    wait_ready();
    // Erase the map, then read it and one byte past the end
    unlock();
    send({OP_GRD_ER, 32'h0}, 1, 0);
    idle();
    repeat (33) exp_rx.push_back(8'hFF);
    send({OP_GRD_RD, 32'h0}, 4, 33);
    // Guard sector 0 and sector 255
    unlock();
    send({OP_GRD_PG, 24'h000000, 8'hFE}, 5, 0);
    idle();
    unlock();
    send({OP_GRD_PG, 24'h00001F, 8'h7F}, 5, 0);
    idle();
    // Broken unlock run: map erase must be dropped
    send({OP_WREN, 32'h0}, 1, 0);
    send({OP_KEY1, 32'h0}, 1, 0);
    send({OP_KEY2, 32'h0}, 1, 0);
    send({OP_RDSR, 32'h0}, 1, 0);
    send({OP_GRD_ER, 32'h0}, 1, 0);
    idle();
    exp_rx = '{8'hFE, 8'hFF, 8'hFF, 8'h7F, 8'hFF};
    send({OP_GRD_RD, 32'h0}, 4, 2);
    send({OP_GRD_RD, 24'h00001E, 8'h0}, 4, 3);
    // Array operations on guarded and open sectors, faster host
    u_host.half = 6;
    for (int i = 0; i < 6; i++) begin
      lfsr = rnd(lfsr);
      a = opv[i];
      if (i < 5) begin
        a[7:0] = lfsr;
      end
      if (open_ok[i]) begin
        exp_op.push_back({kinds[i], a[23:0]});
      end
      send({OP_WREN, 32'h0}, 1, 0);
      send({a, lfsr}, i == 5 ? 1 : (a[31:24] == OP_PP ? 5 : 4), 0);
      idle();
      chk("latch spent", 0, write_latch_flag);
    end
    // Supply drop clears the latch and blocks writes
    send({OP_WREN, 32'h0}, 1, 0);
    chk("latch set", 1, write_latch_flag);
    vcc_ok_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    chk("latch on supply drop", 0, write_latch_flag);
    chk("ready on supply drop", 0, ready);
    vcc_ok_i <= 1'b1;
    wait_ready();
    chk("pending results", 0, exp_rx.size() + exp_op.size());
    stop_test();
  end
endmodule
